// ===== rtl/pcrs_pkg.sv
package pcrs_pkg;

   // ==========================================================
   // Widths and basic types
   // ==========================================================
   localparam int PC_W = 21;
   localparam int PTR_W = 5;
   localparam int STACK_DEPTH = 31;

   typedef logic [PC_W-1:0] pcrs_pc_t;
   typedef logic [PTR_W-1:0] pcrs_ptr_t;
   typedef logic [7:0] pcrs_byte_t;
   typedef logic [4:0] pcrs_upper_t;

   // ==========================================================
   // Reset values and arithmetic constants
   // ==========================================================
   localparam pcrs_pc_t PC_RESET = 21'h000000;
   localparam pcrs_pc_t PC_STEP = 21'h000002;
   localparam pcrs_pc_t PC_ALIGN_MASK = 21'h1FFFFE;
   localparam pcrs_pc_t PC_ZERO = 21'h000000;
   localparam pcrs_byte_t PCL_ALIGN_MASK = 8'hFE;
   localparam pcrs_byte_t BYTE_ZERO = 8'h00;
   localparam pcrs_byte_t LATH_RESET = 8'h00;
   localparam pcrs_upper_t LATU_RESET = 5'h00;
   localparam pcrs_ptr_t PTR_EMPTY = 5'h00;
   localparam pcrs_ptr_t PTR_ONE = 5'h01;
   localparam pcrs_ptr_t PTR_MAX = 5'h1F;
   localparam logic [2:0] PAD3_ZERO = 3'h0;

   // ==========================================================
   // Field positions of the power control status byte
   // ==========================================================
   localparam int OVF_BIT = 7;
   localparam int UNF_BIT = 6;

   // ==========================================================
   // Sequencer operations and special register selects
   // ==========================================================
   typedef enum logic [2:0] {
      PCRS_OP_NONE,
      PCRS_OP_FETCH,
      PCRS_OP_JUMP,
      PCRS_OP_CALL,
      PCRS_OP_IRQ_ACK,
      PCRS_OP_RETURN,
      PCRS_OP_SW_PUSH,
      PCRS_OP_SW_POP
   } pcrs_op_t;

   typedef enum logic [2:0] {
      PCRS_SEL_PCL,
      PCRS_SEL_PC_HIGH_LATCH,
      PCRS_SEL_PC_UPPER_LATCH,
      PCRS_SEL_TOP_OF_STACK_LOW,
      PCRS_SEL_TOP_OF_STACK_HIGH,
      PCRS_SEL_TOP_OF_STACK_UPPER,
      PCRS_SEL_RETURN_STACK_POINTER,
      PCRS_SEL_PCON
   } pcrs_sel_t;

   typedef struct packed {
      pcrs_op_t op;
      pcrs_pc_t target;
   } pcrs_cmd_t;

   typedef struct packed {
      pcrs_sel_t sel;
      logic wr;
      logic rd;
      pcrs_byte_t wdata;
   } pcrs_sfr_t;

endpackage : pcrs_pkg

// ===== rtl/pcrs_stack_mem.sv
module pcrs_stack_mem (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire pcrs_pkg::pcrs_ptr_t wr_addr,
   input wire pcrs_pkg::pcrs_pc_t wr_data,
   input wire pcrs_pkg::pcrs_ptr_t rd_addr,
   output pcrs_pkg::pcrs_pc_t rd_data
);
   import pcrs_pkg::*;

   // ==========================================================
   // Storage for entries 1 to 31; index zero has no cell
   // ==========================================================
   pcrs_pc_t mem [1:STACK_DEPTH];
   pcrs_pc_t rd_reg;
   pcrs_pc_t rd_next;

   // Write port; address zero is dropped.
   always_ff @(posedge clk) begin
      if (wr_en && (wr_addr != PTR_EMPTY)) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read value with write-through so the top entry is never stale.
   always_comb begin
      if (rd_addr == PTR_EMPTY) begin
         rd_next = PC_ZERO;
      end else if (wr_en && (wr_addr == rd_addr)) begin
         rd_next = wr_data;
      end else begin
         rd_next = mem[rd_addr];
      end
   end

   // Registered read data.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_reg <= PC_ZERO;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign rd_data = rd_reg;

endmodule : pcrs_stack_mem

// ===== rtl/pcrs_fault_flags.sv
module pcrs_fault_flags (
   input wire logic clk,
   input wire logic por_n,
   input wire logic ovf_event,
   input wire logic unf_event,
   input wire logic sw_write,
   input wire pcrs_pkg::pcrs_byte_t sw_data,
   output logic stack_overflow_flag,
   output logic stack_underflow_flag
);
   import pcrs_pkg::*;

   // ==========================================================
   // Sticky fault flags, cleared only by software or power-on
   // ==========================================================
   logic ovf_reg;
   logic ovf_next;
   logic unf_reg;
   logic unf_next;

   // A hardware event wins over a software write in the same cycle.
   always_comb begin
      ovf_next = ovf_reg;
      unf_next = unf_reg;
      if (sw_write) begin
         ovf_next = sw_data[OVF_BIT];
         unf_next = sw_data[UNF_BIT];
      end
      if (ovf_event) begin
         ovf_next = 1'b1;
      end
      if (unf_event) begin
         unf_next = 1'b1;
      end
   end

   // Of the two resets only power-on clears the flags; device reset leaves them.
   always_ff @(posedge clk) begin
      if (!por_n) begin
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         ovf_reg <= ovf_next;
         unf_reg <= unf_next;
      end
   end

   assign stack_overflow_flag = ovf_reg;
   assign stack_underflow_flag = unf_reg;

endmodule : pcrs_fault_flags

// ===== rtl/pcrs_top.sv
// Notes on behaviour
// - Program counter is 21 bits, three bytes.
// - Only low byte is directly accessed.
// - Low byte write loads high, upper latches.
// - Low byte read copies high, upper bytes.
// - Bit zero stays zero; fetch adds two.
// - Jumps, calls load counter, latches unused.
// - Calls, interrupts push; returns pop; latches kept.
// - Stack is 31 by 21 with 5-bit pointer.
// - Push increments pointer, then writes counter.
// - Pop loads counter, then decrements pointer.
// - Reset zeroes pointer; zero means empty.
// - Pointer and top entry are software accessible.
// - Thirty-second push sets sticky overflow flag.
// - Enabled overflow resets device, zeroes pointer.
// - Disabled overflow holds pointer at 31.
// - Software setting overflow causes no reset.
// - Pop returning zero sets sticky underflow flag.
// - Enabled underflow loads zero and resets.
// - Disabled underflow loads zero, no reset.
// - Software push stores counter at new top.
// - Software pop only decrements the pointer.
module pcrs_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic por_n,
   input wire logic stack_fault_reset_enable,
   input wire pcrs_pkg::pcrs_cmd_t seq_cmd,
   input wire pcrs_pkg::pcrs_sfr_t sfr_acc,
   output pcrs_pkg::pcrs_byte_t sfr_rdata,
   output pcrs_pkg::pcrs_pc_t pc,
   output pcrs_pkg::pcrs_byte_t pc_high_latch,
   output pcrs_pkg::pcrs_upper_t pc_upper_latch,
   output pcrs_pkg::pcrs_ptr_t return_stack_pointer,
   output pcrs_pkg::pcrs_pc_t top_of_stack_value,
   output logic stack_overflow_flag,
   output logic stack_underflow_flag,
   output logic stack_fault_reset
);
   import pcrs_pkg::*;

   // ==========================================================
   // Helper functions
   // ==========================================================
   // Forces the counter onto an even byte address.
   function automatic pcrs_pc_t pcrs_align(input pcrs_pc_t value);
      pcrs_align = value & PC_ALIGN_MASK;
   endfunction : pcrs_align

   // Decrements the pointer without wrapping below empty.
   function automatic pcrs_ptr_t pcrs_ptr_dec(input pcrs_ptr_t value);
      if (value == PTR_EMPTY) begin
         pcrs_ptr_dec = PTR_EMPTY;
      end else begin
         pcrs_ptr_dec = value - PTR_ONE;
      end
   endfunction : pcrs_ptr_dec

   // ==========================================================
   // State
   // ==========================================================
   // 21-bit counter register
   pcrs_pc_t pc_reg;
   pcrs_pc_t pc_next;
   pcrs_byte_t lath_reg;
   pcrs_byte_t lath_next;
   pcrs_upper_t latu_reg;
   pcrs_upper_t latu_next;
   pcrs_ptr_t ptr_reg;
   pcrs_ptr_t ptr_next;
   pcrs_byte_t rdata_reg;
   pcrs_byte_t rdata_next;
   logic fault_reg;
   logic fault_next;

   logic mem_wr_en;
   pcrs_ptr_t mem_wr_addr;
   pcrs_pc_t mem_wr_data;
   pcrs_pc_t tos_value;
   logic ovf_event;
   logic unf_event;
   logic pcon_write;
   logic do_push;

   // ==========================================================
   // Return stack storage and fault flags
   // ==========================================================
   // Read address follows the next pointer so the top is current.
   // dedicated return storage
   pcrs_stack_mem u_stack_mem (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(mem_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data),
      .rd_addr(ptr_next),
      .rd_data(tos_value)
   );

   assign pcon_write = sfr_acc.wr && (sfr_acc.sel == PCRS_SEL_PCON);

   pcrs_fault_flags u_fault_flags (
      .clk(clk),
      .por_n(por_n),
      .ovf_event(ovf_event),
      .unf_event(unf_event),
      .sw_write(pcon_write),
      .sw_data(sfr_acc.wdata),
      .stack_overflow_flag(stack_overflow_flag),
      .stack_underflow_flag(stack_underflow_flag)
   );

   // ==========================================================
   // Counter, latches and pointer next values
   // ==========================================================
   // Special register writes first; sequencer operations override.
   always_comb begin
      pc_next = pc_reg;
      lath_next = lath_reg;
      latu_next = latu_reg;
      ptr_next = ptr_reg;
      fault_next = 1'b0;
      mem_wr_en = 1'b0;
      mem_wr_addr = ptr_reg;
      mem_wr_data = pc_reg;
      ovf_event = 1'b0;
      unf_event = 1'b0;
      do_push = 1'b0;
      if (sfr_acc.rd && (sfr_acc.sel == PCRS_SEL_PCL)) begin
         lath_next = pc_reg[15:8];
         latu_next = pc_reg[20:16];
      end
      if (sfr_acc.wr) begin
         if (sfr_acc.sel == PCRS_SEL_PCL) begin
            pc_next = {latu_reg, lath_reg, sfr_acc.wdata & PCL_ALIGN_MASK};
         end else if (sfr_acc.sel == PCRS_SEL_PC_HIGH_LATCH) begin
            lath_next = sfr_acc.wdata;
         end else if (sfr_acc.sel == PCRS_SEL_PC_UPPER_LATCH) begin
            latu_next = sfr_acc.wdata[4:0];
         end else if (sfr_acc.sel == PCRS_SEL_RETURN_STACK_POINTER) begin
            ptr_next = sfr_acc.wdata[4:0];
         end else if (ptr_reg != PTR_EMPTY) begin
            mem_wr_en = (sfr_acc.sel == PCRS_SEL_TOP_OF_STACK_LOW) || (sfr_acc.sel == PCRS_SEL_TOP_OF_STACK_HIGH) ||
                        (sfr_acc.sel == PCRS_SEL_TOP_OF_STACK_UPPER);
            mem_wr_data = tos_value;
            if (sfr_acc.sel == PCRS_SEL_TOP_OF_STACK_LOW) begin
               mem_wr_data[7:0] = sfr_acc.wdata;
            end else if (sfr_acc.sel == PCRS_SEL_TOP_OF_STACK_HIGH) begin
               mem_wr_data[15:8] = sfr_acc.wdata;
            end else begin
               mem_wr_data[20:16] = sfr_acc.wdata[4:0];
            end
         end
      end
      case (seq_cmd.op)
         PCRS_OP_FETCH: begin
            pc_next = pcrs_align(pc_reg + PC_STEP);
         end
         PCRS_OP_JUMP: begin
            pc_next = pcrs_align(seq_cmd.target);
         end
         PCRS_OP_CALL, PCRS_OP_IRQ_ACK: begin
            do_push = 1'b1;
            pc_next = pcrs_align(seq_cmd.target);
         end
         PCRS_OP_SW_PUSH: begin
            do_push = 1'b1;
         end
         PCRS_OP_RETURN: begin
            pc_next = pcrs_align(tos_value);
            ptr_next = pcrs_ptr_dec(ptr_reg);
            mem_wr_en = 1'b0;
            if (tos_value == PC_ZERO) begin
               unf_event = 1'b1;
               fault_next = stack_fault_reset_enable;
            end
         end
         PCRS_OP_SW_POP: begin
            ptr_next = pcrs_ptr_dec(ptr_reg);
            mem_wr_en = 1'b0;
         end
         default: begin
         end
      endcase
      if (do_push) begin
         mem_wr_data = pc_reg;
         if (ptr_reg == PTR_MAX) begin
            ovf_event = 1'b1;
            if (stack_fault_reset_enable) begin
               fault_next = 1'b1;
               ptr_next = PTR_EMPTY;
               mem_wr_en = 1'b0;
            end else begin
               ptr_next = PTR_MAX;
               mem_wr_en = 1'b1;
               mem_wr_addr = PTR_MAX;
            end
         end else begin
            ptr_next = ptr_reg + PTR_ONE;
            mem_wr_en = 1'b1;
            mem_wr_addr = ptr_reg + PTR_ONE;
         end
      end
   end

   // Counter state registers.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pc_reg <= PC_RESET;
         lath_reg <= LATH_RESET;
         latu_reg <= LATU_RESET;
         ptr_reg <= PTR_EMPTY;
         fault_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         lath_reg <= lath_next;
         latu_reg <= latu_next;
         ptr_reg <= ptr_next;
         fault_reg <= fault_next;
      end
   end

   // ==========================================================
   // Special register read data
   // ==========================================================
   // empty top reads zero
   always_comb begin
      rdata_next = rdata_reg;
      if (sfr_acc.rd) begin
         case (sfr_acc.sel)
            PCRS_SEL_PCL: rdata_next = pc_reg[7:0];
            PCRS_SEL_PC_HIGH_LATCH: rdata_next = lath_reg;
            PCRS_SEL_PC_UPPER_LATCH: rdata_next = {PAD3_ZERO, latu_reg};
            PCRS_SEL_TOP_OF_STACK_LOW: rdata_next = tos_value[7:0];
            PCRS_SEL_TOP_OF_STACK_HIGH: rdata_next = tos_value[15:8];
            PCRS_SEL_TOP_OF_STACK_UPPER: rdata_next = {PAD3_ZERO, tos_value[20:16]};
            PCRS_SEL_RETURN_STACK_POINTER: rdata_next = {PAD3_ZERO, ptr_reg};
            default: begin
               rdata_next = BYTE_ZERO;
               rdata_next[OVF_BIT] = stack_overflow_flag;
               rdata_next[UNF_BIT] = stack_underflow_flag;
            end
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_reg <= BYTE_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign pc = pc_reg;
   assign pc_high_latch = lath_reg;
   assign pc_upper_latch = latu_reg;
   assign return_stack_pointer = ptr_reg;
   assign top_of_stack_value = tos_value;
   assign stack_fault_reset = fault_reg;

   // ==========================================================
   // Assertions
   // ==========================================================
   logic push_op;
   assign push_op = (seq_cmd.op == PCRS_OP_CALL) || (seq_cmd.op == PCRS_OP_IRQ_ACK) ||
                    (seq_cmd.op == PCRS_OP_SW_PUSH);

   sequence s_push_ok;
      push_op && (ptr_reg != PTR_MAX);
   endsequence

   sequence s_entry_written;
      (return_stack_pointer == $past(ptr_reg) + PTR_ONE) && (top_of_stack_value == $past(pc_reg));
   endsequence

   property p_lsb_zero;
      @(posedge clk) disable iff (!reset_n) pc[0] == 1'b0;
   endproperty
   a_lsb_zero: assert property (p_lsb_zero) else $error("Counter bit zero set.");

   property p_fetch_step;
      @(posedge clk) disable iff (!reset_n)
         seq_cmd.op == PCRS_OP_FETCH |=> pc == pcrs_align($past(pc) + PC_STEP);
   endproperty
   a_fetch_step: assert property (p_fetch_step) else $error("Fetch did not add two.");

   property p_pcl_write;
      @(posedge clk) disable iff (!reset_n)
         sfr_acc.wr && sfr_acc.sel == PCRS_SEL_PCL && seq_cmd.op == PCRS_OP_NONE |=>
         pc == {$past(pc_upper_latch), $past(pc_high_latch), $past(sfr_acc.wdata) & PCL_ALIGN_MASK};
   endproperty
   a_pcl_write: assert property (p_pcl_write) else $error("Low byte write ignored latches.");

   property p_pcl_read;
      @(posedge clk) disable iff (!reset_n)
         sfr_acc.rd && sfr_acc.sel == PCRS_SEL_PCL && !sfr_acc.wr |=>
         pc_high_latch == $past(pc[15:8]) && pc_upper_latch == $past(pc[20:16]);
   endproperty
   a_pcl_read: assert property (p_pcl_read) else $error("Low byte read did not copy.");

   property p_push;
      @(posedge clk) disable iff (!reset_n) s_push_ok |=> s_entry_written;
   endproperty
   a_push: assert property (p_push) else $error("Push did not store counter.");

   property p_ovf_fault;
      @(posedge clk) disable iff (!reset_n)
         push_op && ptr_reg == PTR_MAX && stack_fault_reset_enable |=>
         stack_fault_reset && return_stack_pointer == PTR_EMPTY && stack_overflow_flag;
   endproperty
   a_ovf_fault: assert property (p_ovf_fault) else $error("Overflow reset missing.");

   property p_ovf_hold;
      @(posedge clk) disable iff (!reset_n)
         push_op && ptr_reg == PTR_MAX && !stack_fault_reset_enable |=>
         !stack_fault_reset && return_stack_pointer == PTR_MAX && stack_overflow_flag;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("Overflow without reset wrong.");

   property p_underflow;
      @(posedge clk) disable iff (!reset_n)
         seq_cmd.op == PCRS_OP_RETURN && ptr_reg == PTR_EMPTY |=>
         pc == PC_ZERO && stack_underflow_flag && stack_fault_reset == $past(stack_fault_reset_enable);
   endproperty
   a_underflow: assert property (p_underflow) else $error("Underflow handling wrong.");

   property p_reset_ptr;
      @(posedge clk) !reset_n |=> return_stack_pointer == PTR_EMPTY && top_of_stack_value == PC_ZERO;
   endproperty
   a_reset_ptr: assert property (p_reset_ptr) else $error("Reset left pointer set.");

   property p_sw_pop;
      @(posedge clk) disable iff (!reset_n)
         seq_cmd.op == PCRS_OP_SW_POP && ptr_reg != PTR_EMPTY |=>
         return_stack_pointer == $past(ptr_reg) - PTR_ONE && pc == $past(pc);
   endproperty
   a_sw_pop: assert property (p_sw_pop) else $error("Software pop wrong.");

endmodule : pcrs_top

// ===== bench/pcrs_seq_model.sv
module pcrs_seq_model (
   input wire logic reset_n,
   input wire pcrs_pkg::pcrs_op_t req_op,
   input wire pcrs_pkg::pcrs_pc_t req_target,
   input wire pcrs_pkg::pcrs_sfr_t sfr_acc,
   output pcrs_pkg::pcrs_cmd_t seq_cmd
);
   import pcrs_pkg::*;

   // ==========================================================
   // Sequencer command issue
   // ==========================================================
   logic top_busy;

   // interrupts masked around top access
   // A top-of-stack access holds off every sequencer operation, as masked interrupts would.
   assign top_busy = (sfr_acc.wr | sfr_acc.rd) & (sfr_acc.sel inside {PCRS_SEL_TOP_OF_STACK_LOW, PCRS_SEL_TOP_OF_STACK_HIGH, PCRS_SEL_TOP_OF_STACK_UPPER});

   // No operation is issued while the device is held in reset.
   assign seq_cmd = (!reset_n || top_busy) ? pcrs_cmd_t'{op: PCRS_OP_NONE, target: PC_ZERO}
                                           : pcrs_cmd_t'{op: req_op, target: req_target};

endmodule : pcrs_seq_model

// ===== bench/program_counter_return_stack_bench.sv
module program_counter_return_stack_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pcrs_pkg::*;

   // ==========================================================
   // Stimulus and observation signals
   // ==========================================================
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic por_n = 1'b0;
   logic stack_fault_reset_enable = 1'b0;
   pcrs_op_t req_op = PCRS_OP_NONE;
   pcrs_pc_t req_target = PC_ZERO;
   pcrs_sfr_t sfr_acc = '0;
   pcrs_cmd_t seq_cmd;
   pcrs_byte_t sfr_rdata, pc_high_latch;
   pcrs_pc_t pc, top_of_stack_value;
   pcrs_upper_t pc_upper_latch;
   pcrs_ptr_t return_stack_pointer;
   logic stack_overflow_flag, stack_underflow_flag, stack_fault_reset;
   int errors = 0;
   int cmp_count = 0;

   // The clock toggles every half period of 2.5 ns.
   always #2.5 clk = ~clk;

   pcrs_seq_model seq_model (.reset_n(reset_n), .req_op(req_op), .req_target(req_target),
                             .sfr_acc(sfr_acc), .seq_cmd(seq_cmd));

   pcrs_top DUT (.clk(clk), .reset_n(reset_n), .por_n(por_n), .stack_fault_reset_enable(stack_fault_reset_enable),
                 .seq_cmd(seq_cmd), .sfr_acc(sfr_acc), .sfr_rdata(sfr_rdata), .pc(pc),
                 .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
                 .return_stack_pointer(return_stack_pointer), .top_of_stack_value(top_of_stack_value),
                 .stack_overflow_flag(stack_overflow_flag), .stack_underflow_flag(stack_underflow_flag),
                 .stack_fault_reset(stack_fault_reset));

   // ==========================================================
   // Compare and report tasks
   // ==========================================================
   task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   // Checks counter, pointer and top entry together.
   task automatic state(input pcrs_pc_t p, input pcrs_ptr_t s, input pcrs_pc_t t);
      chk("pc", p, pc);
      chk("pointer", 21'(s), 21'(return_stack_pointer));
      chk("top value", t, top_of_stack_value);
   endtask : state

   task automatic flags(input logic ovf, input logic unf, input logic fault);
      chk_bit("overflow flag", ovf, stack_overflow_flag);
      chk_bit("underflow flag", unf, stack_underflow_flag);
      chk_bit("fault reset", fault, stack_fault_reset);
   endtask : flags

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // ==========================================================
   // Access tasks; each returns just after the taking edge
   // ==========================================================
   task automatic seq(input pcrs_op_t op, input pcrs_pc_t tgt);
      @(posedge clk) #1;
      req_op = op;
      req_target = tgt;
      @(posedge clk) #1;
      req_op = PCRS_OP_NONE;
   endtask : seq

   task automatic sfr_wr(input pcrs_sel_t sel, input pcrs_byte_t d);
      @(posedge clk) #1;
      sfr_acc = {sel, 1'b1, 1'b0, d};
      @(posedge clk) #1;
      sfr_acc = '0;
   endtask : sfr_wr

   task automatic sfr_rd(input pcrs_sel_t sel, input pcrs_byte_t exp);
      @(posedge clk) #1;
      sfr_acc = {sel, 1'b0, 1'b1, BYTE_ZERO};
      @(posedge clk) #1;
      sfr_acc = '0;
      chk(sel.name(), 21'(exp), 21'(sfr_rdata));
   endtask : sfr_rd

   // Device reset for 12 cycles, with power-on reset when asked.
   task automatic do_reset(input logic power);
      @(posedge clk) #1;
      reset_n = 1'b0;
      por_n = ~power;
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      por_n = 1'b1;
   endtask : do_reset

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      do_reset(1'b1);
      state(PC_ZERO, PTR_EMPTY, PC_ZERO);
      flags(1'b0, 1'b0, 1'b0);
      sfr_rd(PCRS_SEL_TOP_OF_STACK_LOW, 8'h00);
      done("reset");
      seq(PCRS_OP_FETCH, PC_ZERO);
      chk("pc", 21'h000002, pc);
      sfr_wr(PCRS_SEL_PC_HIGH_LATCH, 8'hA5);
      sfr_wr(PCRS_SEL_PC_UPPER_LATCH, 8'h1B);
      seq(PCRS_OP_JUMP, 21'h012345);
      chk("pc", 21'h012344, pc);
      sfr_rd(PCRS_SEL_PCL, 8'h44);
      chk("latches", 21'h000123, {pc_upper_latch, pc_high_latch});
      sfr_wr(PCRS_SEL_PC_HIGH_LATCH, 8'h5A);
      sfr_wr(PCRS_SEL_PC_UPPER_LATCH, 8'h0C);
      sfr_wr(PCRS_SEL_PCL, 8'h37);
      chk("pc", 21'h0C5A36, pc);
      done("counter");
      seq(PCRS_OP_CALL, 21'h000101);
      state(21'h000100, 5'h01, 21'h0C5A36);
      seq(PCRS_OP_IRQ_ACK, 21'h000008);
      state(21'h000008, 5'h02, 21'h000100);
      seq(PCRS_OP_RETURN, PC_ZERO);
      state(21'h000100, 5'h01, 21'h0C5A36);
      chk("latches", 21'h000C5A, {pc_upper_latch, pc_high_latch});
      seq(PCRS_OP_RETURN, PC_ZERO);
      state(21'h0C5A36, PTR_EMPTY, PC_ZERO);
      done("call return");
      seq(PCRS_OP_SW_PUSH, PC_ZERO);
      state(21'h0C5A36, 5'h01, 21'h0C5A36);
      sfr_wr(PCRS_SEL_TOP_OF_STACK_LOW, 8'h10);
      sfr_wr(PCRS_SEL_TOP_OF_STACK_HIGH, 8'h32);
      sfr_wr(PCRS_SEL_TOP_OF_STACK_UPPER, 8'h04);
      chk("top value", 21'h043210, top_of_stack_value);
      sfr_rd(PCRS_SEL_TOP_OF_STACK_HIGH, 8'h32);
      sfr_rd(PCRS_SEL_RETURN_STACK_POINTER, 8'h01);
      seq(PCRS_OP_SW_PUSH, PC_ZERO);
      seq(PCRS_OP_SW_POP, PC_ZERO);
      state(21'h0C5A36, 5'h01, 21'h043210);
      seq(PCRS_OP_RETURN, PC_ZERO);
      state(21'h043210, PTR_EMPTY, PC_ZERO);
      sfr_wr(PCRS_SEL_RETURN_STACK_POINTER, 8'h1F);
      sfr_rd(PCRS_SEL_RETURN_STACK_POINTER, 8'h1F);
      sfr_wr(PCRS_SEL_RETURN_STACK_POINTER, 8'h00);
      done("software stack");
      // Thirty-one pushes fill the stack, alternating calls and interrupt entries.
      for (int i = 1; i <= 31; i++) begin
         seq(i[0] ? PCRS_OP_CALL : PCRS_OP_IRQ_ACK, 21'(i * 4));
      end
      state(21'h00007C, PTR_MAX, 21'h000078);
      flags(1'b0, 1'b0, 1'b0);
      seq(PCRS_OP_CALL, 21'h000200);
      state(21'h000200, PTR_MAX, 21'h00007C);
      flags(1'b1, 1'b0, 1'b0);
      seq(PCRS_OP_SW_PUSH, PC_ZERO);
      state(21'h000200, PTR_MAX, 21'h000200);
      sfr_rd(PCRS_SEL_PCON, 8'h80);
      sfr_wr(PCRS_SEL_PCON, 8'h00);
      chk_bit("overflow flag", 1'b0, stack_overflow_flag);
      sfr_wr(PCRS_SEL_PCON, 8'h80);
      flags(1'b1, 1'b0, 1'b0);
      sfr_wr(PCRS_SEL_PCON, 8'h00);
      done("overflow held");
      stack_fault_reset_enable = 1'b1;
      seq(PCRS_OP_CALL, 21'h000300);
      chk("pointer", 21'h000000, 21'(return_stack_pointer));
      flags(1'b1, 1'b0, 1'b1);
      do_reset(1'b0);
      state(PC_ZERO, PTR_EMPTY, PC_ZERO);
      chk_bit("overflow flag", 1'b1, stack_overflow_flag);
      sfr_wr(PCRS_SEL_PCON, 8'h00);
      done("overflow reset");
      stack_fault_reset_enable = 1'b0;
      seq(PCRS_OP_JUMP, 21'h000040);
      seq(PCRS_OP_RETURN, PC_ZERO);
      state(PC_ZERO, PTR_EMPTY, PC_ZERO);
      flags(1'b0, 1'b1, 1'b0);
      sfr_rd(PCRS_SEL_PCON, 8'h40);
      sfr_wr(PCRS_SEL_PCON, 8'h00);
      seq(PCRS_OP_SW_POP, PC_ZERO);
      flags(1'b0, 1'b0, 1'b0);
      stack_fault_reset_enable = 1'b1;
      seq(PCRS_OP_JUMP, 21'h000040);
      seq(PCRS_OP_RETURN, PC_ZERO);
      chk("pc", PC_ZERO, pc);
      flags(1'b0, 1'b1, 1'b1);
      done("underflow");
      finish_test();
   end

   // A run that outlasts its cycle budget is cut short as a mismatch.
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("unexpected run length: expected end before 20000 cycles seen none");
      finish_test();
   end

endmodule : program_counter_return_stack_bench
